// ---- inc/istr_defines.svh ----
// Purpose: constants for the tuning register bank
// Assumes: 8-bit registers addressed by a 6-bit register index
// Notes:   included by the design module and the bench
`ifndef ISTR_DEFINES_SVH
`define ISTR_DEFINES_SVH
`define ISTR_OFF_TC_FIRST   6'h02
`define ISTR_OFF_TC_SECOND  6'h03
`define ISTR_OFF_DIG_CONV   6'h04
`define ISTR_RST_TC_FIRST   8'h90
`define ISTR_RST_TC_SECOND  8'ha0
`define ISTR_RST_DIG_CONV   8'h03
`define ISTR_FIRST_CAP_MSB  7
`define ISTR_FIRST_CAP_LSB  6
`define ISTR_FIRST_RSV_BIT  5
`define ISTR_FIRST_RES_MSB  4
`define ISTR_DIG_FLOOR_MSB  7
`define ISTR_DIG_FLOOR_LSB  4
`define ISTR_DIG_RSV_BIT    3
`define ISTR_DIG_PER_MSB    2
// Resistance bases and step in ohms, and the base period count
`define ISTR_FIRST_RES_BASE_OHM  32'd417000
`define ISTR_SECOND_RES_BASE_OHM 32'd835000
`define ISTR_R_STEP_OHM     32'd12770
`define ISTR_PER_BASE       16'h0060
`endif

// ---- inc/istr_pkg.sv ----
// Purpose: types for the tuning register bank
// Assumes: nothing beyond the defines header
// Notes:   holds types only
package istr_pkg;
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } istr_req_t;
  typedef struct packed {
    logic [1:0] first_constant_capacitance;
    logic [4:0] first_constant_resistance;
    logic [1:0] second_constant_capacitance;
    logic [5:0] second_constant_resistance;
    logic [3:0] sensor_floor_frequency_code;
    logic [2:0] conversion_period_select;
  } istr_cfg_t;
  typedef enum logic [1:0] {
    ISTR_IDLE = 2'b00,
    ISTR_RESP = 2'b01
  } istr_state_t;
endpackage

// ---- rtl/istr_regs.sv ----
// Purpose: three read/write tuning registers of an inductive sensor converter
// Assumes: register port framing is decoded elsewhere into one-cycle strobes
// Notes:   rd_data and rd_valid follow a read strobe by one cycle
`timescale 1ns/100ps
`include "istr_defines.svh"
module istr_regs (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire istr_pkg::istr_req_t req,
  output logic [7:0]               rd_data,
  output logic                     rd_valid,
  output istr_pkg::istr_cfg_t      cfg,
  output logic [3:0]               first_cap_quarter_pf,
  output logic [4:0]               second_cap_pf_div3,
  output logic [15:0]              periods_per_conversion
);
  logic [7:0]            tc_first_reg;
  logic [7:0]            tc_second_reg;
  logic [7:0]            dig_conv_reg;
  istr_pkg::istr_state_t state_reg;

  // Decode of a write to one register index, used three times
  function automatic logic hit(input istr_pkg::istr_req_t r, input logic [5:0] off);
    hit = r.wr_en && (r.addr == off);
  endfunction

  // One-hot capacitance multiple, code n gives 2**n units
  function automatic logic [4:0] cap_mult(input logic [1:0] code);
    cap_mult = 5'h01 << code;
  endfunction

  // First time-constant register, every bit stored as written
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tc_first_reg <= `ISTR_RST_TC_FIRST;
    end else if (clk_en && hit(req, `ISTR_OFF_TC_FIRST)) begin
      tc_first_reg <= req.wdata;
    end
  end

  // Second time-constant register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tc_second_reg <= `ISTR_RST_TC_SECOND;
    end else if (clk_en && hit(req, `ISTR_OFF_TC_SECOND)) begin
      tc_second_reg <= req.wdata;
    end
  end

  // Conversion config; spare bit kept so reads echo writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dig_conv_reg <= `ISTR_RST_DIG_CONV;
    end else if (clk_en && hit(req, `ISTR_OFF_DIG_CONV)) begin
      dig_conv_reg <= req.wdata;
    end
  end

  // Read port, unmapped indices return zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data   <= 8'h00;
      rd_valid  <= 1'b0;
      state_reg <= istr_pkg::ISTR_IDLE;
    end else if (clk_en) begin
      rd_valid <= req.rd_en;
      case (state_reg)
        istr_pkg::ISTR_IDLE: begin
          if (req.rd_en) begin
            state_reg <= istr_pkg::ISTR_RESP;
          end
        end
        istr_pkg::ISTR_RESP: begin
          if (!req.rd_en) begin
            state_reg <= istr_pkg::ISTR_IDLE;
          end
        end
        default: begin
          state_reg <= istr_pkg::ISTR_IDLE;
        end
      endcase
      if (req.rd_en) begin
        case (req.addr)
          `ISTR_OFF_TC_FIRST:  rd_data <= tc_first_reg;
          `ISTR_OFF_TC_SECOND: rd_data <= tc_second_reg;
          `ISTR_OFF_DIG_CONV:  rd_data <= dig_conv_reg;
          default:             rd_data <= 8'h00;
        endcase
      end
    end
  end

  // Field outputs registered so the analogue side sees clean levels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg                    <= '0;
      first_cap_quarter_pf   <= 4'h0;
      second_cap_pf_div3     <= 5'h00;
      periods_per_conversion <= 16'h0000;
    end else if (clk_en) begin
      cfg.first_constant_capacitance <=
        tc_first_reg[`ISTR_FIRST_CAP_MSB:`ISTR_FIRST_CAP_LSB];
      cfg.first_constant_resistance <= tc_first_reg[`ISTR_FIRST_RES_MSB:0];
      cfg.second_constant_capacitance <= tc_second_reg[7:6];
      cfg.second_constant_resistance <= tc_second_reg[5:0];
      cfg.sensor_floor_frequency_code <=
        dig_conv_reg[`ISTR_DIG_FLOOR_MSB:`ISTR_DIG_FLOOR_LSB];
      cfg.conversion_period_select <= dig_conv_reg[`ISTR_DIG_PER_MSB:0];
      // Units of 0.75 pF: 1,2,4,8 -> 0.75..6.0 pF, four bits so 6.0 pF does not wrap
      first_cap_quarter_pf <= 4'(cap_mult(tc_first_reg[7:6]));
      // Units of 3 pF: 1,2,4,8 -> 3..24 pF
      second_cap_pf_div3 <= cap_mult(tc_second_reg[7:6]);
      // Reserved codes below 010 yield zero rather than a bogus period
      if (dig_conv_reg[2:1] == 2'b00) begin
        periods_per_conversion <= 16'h0000;
      end else begin
        periods_per_conversion <=
          `ISTR_PER_BASE << (dig_conv_reg[2:0] - 3'h1);
      end
    end
  end

  // Checks
  property p_first_reset;
    @(posedge core_clk) $fell(rst) |-> tc_first_reg == `ISTR_RST_TC_FIRST;
  endproperty
  a_first_reset: assert property (p_first_reset) else $error("first reset value wrong");

  property p_second_reset;
    @(posedge core_clk) $fell(rst) |-> tc_second_reg == `ISTR_RST_TC_SECOND;
  endproperty
  a_second_reset: assert property (p_second_reset) else $error("second reset value wrong");

  property p_dig_reset;
    @(posedge core_clk) $fell(rst) |-> dig_conv_reg == `ISTR_RST_DIG_CONV;
  endproperty
  a_dig_reset: assert property (p_dig_reset) else $error("config reset value wrong");

  sequence s_write_first;
    clk_en && req.wr_en && req.addr == `ISTR_OFF_TC_FIRST;
  endsequence
  property p_first_write;
    @(posedge core_clk) disable iff (rst)
      s_write_first |=> tc_first_reg == $past(req.wdata);
  endproperty
  a_first_write: assert property (p_first_write) else $error("first write lost");

  property p_second_write;
    @(posedge core_clk) disable iff (rst)
      clk_en && req.wr_en && req.addr == `ISTR_OFF_TC_SECOND
      |=> tc_second_reg == $past(req.wdata);
  endproperty
  a_second_write: assert property (p_second_write) else $error("second write lost");

  sequence s_read_dig;
    clk_en && req.rd_en && req.addr == `ISTR_OFF_DIG_CONV;
  endsequence
  property p_read_dig;
    @(posedge core_clk) disable iff (rst)
      s_read_dig |=> rd_valid && rd_data == $past(dig_conv_reg);
  endproperty
  a_read_dig: assert property (p_read_dig) else $error("config readback wrong");

  property p_cap1;
    @(posedge core_clk) disable iff (rst)
      clk_en |=> first_cap_quarter_pf == 4'(5'h01 << $past(tc_first_reg[7:6]));
  endproperty
  a_cap1: assert property (p_cap1) else $error("first cap decode wrong");

  property p_cap2;
    @(posedge core_clk) disable iff (rst)
      clk_en |=> second_cap_pf_div3 == (5'h01 << $past(tc_second_reg[7:6]));
  endproperty
  a_cap2: assert property (p_cap2) else $error("second cap decode wrong");

  property p_period_max;
    @(posedge core_clk) disable iff (rst)
      clk_en && dig_conv_reg[2:0] == 3'h7 |=> periods_per_conversion == 16'd6144;
  endproperty
  a_period_max: assert property (p_period_max) else $error("period decode wrong");

  property p_floor;
    @(posedge core_clk) disable iff (rst)
      clk_en |=> cfg.sensor_floor_frequency_code == $past(dig_conv_reg[7:4]);
  endproperty
  a_floor: assert property (p_floor) else $error("floor code wrong");

  property p_dig_write;
    @(posedge core_clk) disable iff (rst)
      clk_en && req.wr_en && req.addr == `ISTR_OFF_DIG_CONV
      |=> dig_conv_reg == $past(req.wdata);
  endproperty
  a_dig_write: assert property (p_dig_write) else $error("config write lost");

  sequence s_read_first;
    clk_en && req.rd_en && req.addr == `ISTR_OFF_TC_FIRST;
  endsequence
  property p_read_first;
    @(posedge core_clk) disable iff (rst)
      s_read_first |=> rd_valid && rd_data == $past(tc_first_reg);
  endproperty
  a_read_first: assert property (p_read_first) else $error("first readback wrong");

  // A strobe during a frozen cycle must not slip into a register
  property p_freeze;
    @(posedge core_clk) disable iff (rst)
      !clk_en |=> $stable(tc_first_reg) && $stable(tc_second_reg) && $stable(dig_conv_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("register moved while frozen");

  property p_per_dflt;
    @(posedge core_clk) disable iff (rst)
      clk_en && dig_conv_reg[2:0] == 3'h3 |=> periods_per_conversion == 16'h0180;
  endproperty
  a_per_dflt: assert property (p_per_dflt) else $error("default period wrong");
endmodule

// ---- tb/istr_host_model.sv ----
// Purpose: host model that issues register strobes to the tuning bank
// Assumes: strobes change on falling edges of core_clk
// Notes:   spare bits and unused period codes are never sent
`timescale 1ns/100ps
module istr_host_model (
  input  wire logic           core_clk,
  output istr_pkg::istr_req_t req,
  input  wire logic [7:0]     rd_data,
  input  wire logic           rd_valid
);
  initial req = '0;
  // One write strobe; a careful host cleans the value first
  task automatic wr(input logic [5:0] a, input logic [7:0] dat);
    logic [7:0] v;
    v = dat;
    if (a == 6'h02) v[5] = 1'b0;
    if (a == 6'h04) v[3] = 1'b0;
    // Reserved period codes 000 and 001 are replaced by the default code 011
    if (a == 6'h04 && v[2:1] == 2'b00) v[2:0] = 3'h3;
    @(negedge core_clk);
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
    @(negedge core_clk);
    req = '0;
  endtask
  // One read strobe; answer is sampled a cycle later, off the edge
  task automatic rd(input logic [5:0] a, output logic [7:0] dat, output logic ok);
    @(negedge core_clk);
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'hff};
    @(negedge core_clk);
    req = '0;
    ok = rd_valid;
    dat = rd_data;
  endtask
endmodule

// ---- tb/inductive_sensor_tuning_regs_tb.sv ----
// Purpose: self-checking bench for the tuning register bank
// Assumes: host model drives strobes, bench drives clk_en and rst
// Notes:   expected decodes are worked out here, not read back
`timescale 1ns/100ps
`include "istr_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module inductive_sensor_tuning_regs_tb;
  logic                core_clk = 1'b0;
  logic                rst = 1'b1;
  logic                clk_en = 1'b1;
  istr_pkg::istr_req_t req;
  logic [7:0]          rd_data;
  logic                rd_valid;
  istr_pkg::istr_cfg_t cfg;
  logic [3:0]          c1q;
  logic [4:0]          c2q;
  logic [15:0]         per;
  int                  bad_count = 0;
  int                  total_checks = 0;
  logic [7:0]          d;
  logic                ok;
  istr_regs i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .cfg(cfg), .first_cap_quarter_pf(c1q),
    .second_cap_pf_div3(c2q), .periods_per_conversion(per));
  istr_host_model i_host (.core_clk(core_clk), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid));
  // 250 MHz clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    i_host.rd(a, d, ok);
    `CHK("rd_valid", 1'b1, ok)
    `CHK("rd_data", e, d)
  endtask
  // Reset values and their decodes
  task automatic t_reset();
    rd_chk(6'h02, `ISTR_RST_TC_FIRST);
    rd_chk(6'h03, `ISTR_RST_TC_SECOND);
    rd_chk(6'h04, `ISTR_RST_DIG_CONV);
    `CHK("cap1", 4'h4, c1q)
    `CHK("cap2", 5'h4, c2q)
    `CHK("res1", 5'h10, cfg.first_constant_resistance)
    `CHK("res2", 6'h20, cfg.second_constant_resistance)
    `CHK("period code", 3'h3, cfg.conversion_period_select)
    `CHK("floor", 4'h0, cfg.sensor_floor_frequency_code)
    `CHK("periods", 16'd384, per)
  endtask
  // Every cap code, resistance codes at both ends
  task automatic t_caps();
    for (int i = 0; i < 4; i++) begin
      i_host.wr(6'h02, {i[1:0], 1'b0, (i[0] ? 5'h1f : 5'h00)});
      i_host.wr(6'h03, {i[1:0], (i[0] ? 6'h3f : 6'h00)});
      rd_chk(6'h02, {i[1:0], 1'b0, (i[0] ? 5'h1f : 5'h00)});
      rd_chk(6'h03, {i[1:0], (i[0] ? 6'h3f : 6'h00)});
      `CHK("cap1", 4'h1 << i, c1q)
      `CHK("cap1 code", i[1:0], cfg.first_constant_capacitance)
      `CHK("cap2 code", i[1:0], cfg.second_constant_capacitance)
      `CHK("res2", (i[0] ? 6'h3f : 6'h00), cfg.second_constant_resistance)
      `CHK("cap2", 5'h1 << i, c2q)
    end
  endtask
  // Period codes 2..7 with the top floor code
  task automatic t_period();
    for (int c = 2; c < 8; c++) begin
      i_host.wr(6'h04, {4'hf, 1'b0, c[2:0]});
      rd_chk(6'h04, {4'hf, 1'b0, c[2:0]});
      `CHK("periods", 16'd192 << (c - 2), per)
      `CHK("floor", 4'hf, cfg.sensor_floor_frequency_code)
    end
  endtask
  // Spare bit cleared, unmapped read, frozen while disabled
  task automatic t_edge();
    i_host.wr(6'h02, 8'hff);
    rd_chk(6'h02, 8'hdf);
    rd_chk(6'h05, 8'h00);
    clk_en = 1'b0;
    i_host.wr(6'h02, 8'h41);
    clk_en = 1'b1;
    rd_chk(6'h02, 8'hdf);
  endtask
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_caps();
    t_period();
    t_edge();
    final_report();
  end
endmodule
